// ### mcd_color_decoder.sv
`timescale 1ns/1ps
// Operation
// - mix input to baseband at carrier
// - lowpass then interleave at half rate
// - programmable dds subcarrier for substandards
// - time shared chroma lowpass removes luma
// - four bandwidths plus optional peaking term
// - wide band chroma filter for pal ntsc
// - secam uses bell shaped lowpass
// - cordic gives phase and magnitude
// - differentiate phase, deemphasis, scale secam
// - keyed burst drives phase and gain loops
// - secam burst frequency identifies carrier
// - kill colour while phase loop unlocked
// - secam kill on missing line alternation
// - amplitude kill with threshold and hysteresis
// - one line delay stores active video
// - delay use chosen per standard
// - ntsc compensated averages two lines
// - ntsc comb adds back vertical luma detail
// - luma notch tracks chroma carrier
// - skew filters 1/32 luma 1/4 chroma
// - horizontal scaler 0.25 to 4
// - test patterns replace decoded output
// - output is 4:2:2 ycrcb
// - processing at 250/12 = 20.83 mhz sample rate
module mcd_color_decoder (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] vid_in,
    input wire logic key_win,
    input wire logic active_video,
    input wire logic line_start,
    input wire logic [7:0] line_phase,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output mcd_pkg::mcd_pix_t pix_out
);
    // -------------------------------------------------------------
    // sample rate enable
    // -------------------------------------------------------------
    logic [4:0] div_q;
    logic smp;
    assign smp = (div_q == 5'(mcd_pkg::SYS_DIV - 1));
    always_ff @(posedge clk)
    begin
        if (!nrst || smp)
            div_q <= 5'h00;
        else
            div_q <= div_q + 5'h01;
    end
    // -------------------------------------------------------------
    // axi4-lite slave
    // -------------------------------------------------------------
    logic [31:0] ctrl_q, dds_q, kill_q, scale_q, skew_q;
    logic aw_ok_q, w_ok_q;
    logic [7:0] awa_q;
    logic [31:0] wd_q;
    logic [3:0] ws_q;
    logic [31:0] st_w;
    logic do_wr;
    logic wr_hit;
    assign s_axi_awready = !aw_ok_q && !s_axi_bvalid;
    assign s_axi_wready = !w_ok_q && !s_axi_bvalid;
    assign do_wr = aw_ok_q && w_ok_q && !s_axi_bvalid;
    assign wr_hit = awa_q == mcd_pkg::REG_CTRL || awa_q == mcd_pkg::REG_DDS
        || awa_q == mcd_pkg::REG_KILL || awa_q == mcd_pkg::REG_SCALE
        || awa_q == mcd_pkg::REG_SKEW;
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
        input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++)
            if (s[b])
                r[8*b +: 8] = n[8*b +: 8];
        return r;
    endfunction
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            aw_ok_q <= 1'b0;
            w_ok_q <= 1'b0;
            awa_q <= 8'h00;
            wd_q <= 32'h0;
            ws_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            ctrl_q <= mcd_pkg::CTRL_RST;
            dds_q <= mcd_pkg::DDS_RST;
            kill_q <= mcd_pkg::KILL_RST;
            scale_q <= mcd_pkg::SCALE_RST;
            skew_q <= 32'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_ok_q <= 1'b1;
                awa_q <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_ok_q <= 1'b1;
                wd_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end
            if (do_wr)
            begin
                aw_ok_q <= 1'b0;
                w_ok_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
                if (awa_q == mcd_pkg::REG_CTRL)
                    ctrl_q <= merge(ctrl_q, wd_q, ws_q);
                if (awa_q == mcd_pkg::REG_DDS)
                    dds_q <= merge(dds_q, wd_q, ws_q);
                if (awa_q == mcd_pkg::REG_KILL)
                    kill_q <= merge(kill_q, wd_q, ws_q);
                if (awa_q == mcd_pkg::REG_SCALE)
                    scale_q <= merge(scale_q, wd_q, ws_q);
                if (awa_q == mcd_pkg::REG_SKEW)
                    skew_q <= merge(skew_q, wd_q, ws_q);
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end
    logic [7:0] ra;
    logic [31:0] rmux;
    logic rhit;
    assign ra = {s_axi_araddr[7:2], 2'b00};
    assign rhit = ra <= mcd_pkg::REG_SKEW;
    assign rmux = ra == mcd_pkg::REG_CTRL ? ctrl_q : ra == mcd_pkg::REG_DDS ? dds_q :
        ra == mcd_pkg::REG_KILL ? kill_q : ra == mcd_pkg::REG_SCALE ? scale_q :
        ra == mcd_pkg::REG_STAT ? st_w : ra == mcd_pkg::REG_SKEW ? skew_q : 32'h0;
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b00;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rmux;
            s_axi_rresp <= rhit ? 2'b00 : 2'b10;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
    // -------------------------------------------------------------
    // control decode
    // -------------------------------------------------------------
    mcd_pkg::mcd_std_t std_w;
    mcd_pkg::mcd_dly_t dly_w;
    mcd_pkg::mcd_tp_t tp_w;
    logic [1:0] bw_w;
    assign std_w = mcd_pkg::mcd_std_t'(ctrl_q[mcd_pkg::CTL_STD_LSB +: 2]);
    assign bw_w = ctrl_q[mcd_pkg::CTL_BW_LSB +: 2];
    assign tp_w = mcd_pkg::mcd_tp_t'(ctrl_q[mcd_pkg::CTL_TEST_LSB +: 3]);
    assign dly_w = std_w == mcd_pkg::STD_SECAM ? mcd_pkg::DLY_XOVR :
        std_w == mcd_pkg::STD_PAL ? mcd_pkg::DLY_COMP :
        mcd_pkg::mcd_dly_t'(ctrl_q[mcd_pkg::CTL_DLY_LSB +: 2]);
    logic secam;
    assign secam = std_w == mcd_pkg::STD_SECAM;
    // -------------------------------------------------------------
    // dds and quadrature mixer
    // -------------------------------------------------------------
    logic [31:0] ph_q;
    logic [31:0] apc_trim_q;
    logic [31:0] inc_w;
    assign inc_w = secam ? mcd_pkg::SECAM_DDS : dds_q + apc_trim_q;
    always_ff @(posedge clk)
    begin
        if (!nrst)
            ph_q <= 32'h0;
        else if (smp)
            ph_q <= ph_q + inc_w;
    end
    logic signed [8:0] xs;
    logic signed [9:0] mi, mq;
    assign xs = $signed({1'b0, vid_in}) - 9'sh080;
    // four point sine table with sign quadrant
    assign mi = ph_q[31:30] == 2'b00 ? 10'(xs) : ph_q[31:30] == 2'b10 ? -10'(xs) : 10'sh0;
    assign mq = ph_q[31:30] == 2'b01 ? 10'(xs) : ph_q[31:30] == 2'b11 ? -10'(xs) : 10'sh0;
    // -------------------------------------------------------------
    // time shared lowpass, one channel per sample
    // -------------------------------------------------------------
    mcd_pkg::mcd_iq_t acc_q;
    logic tsel_q;
    logic [2:0] sh_w;
    logic signed [9:0] xin, cur, upd;
    // narrow, normal, broad, wide: coefficient as shift
    assign sh_w = ctrl_q[mcd_pkg::CTL_WIDE] && !secam ? 3'h0 :
        secam ? 3'h3 + 3'(bw_w == 2'b00) : 3'h3 - 3'(bw_w);
    assign xin = tsel_q ? mq : mi;
    assign cur = tsel_q ? acc_q.q : acc_q.i;
    assign upd = cur + ((xin - cur) >>> sh_w)
        + (ctrl_q[mcd_pkg::CTL_PEAK] ? ((xin - cur) >>> 3'h4) : 10'sh0);
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            acc_q <= '0;
            tsel_q <= 1'b0;
        end
        else if (smp)
        begin
            tsel_q <= !tsel_q;
            if (tsel_q)
                acc_q.q <= upd;
            else
                acc_q.i <= upd;
        end
    end
    // -------------------------------------------------------------
    // cordic: coarse phase and magnitude
    // -------------------------------------------------------------
    logic [9:0] ai, aq;
    logic [7:0] mag_w, ang_w;
    assign ai = acc_q.i[9] ? 10'(-acc_q.i) : 10'(acc_q.i);
    assign aq = acc_q.q[9] ? 10'(-acc_q.q) : 10'(acc_q.q);
    assign mag_w = (ai > aq) ? 8'(ai + (aq >> 1)) : 8'(aq + (ai >> 1));
    assign ang_w = {acc_q.i[9], acc_q.q[9], (ai > aq), 5'(aq > ai ? ai >> 3 : aq >> 3)};
    logic [7:0] ang_q, frq_q, deem_q;
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            ang_q <= 8'h00;
            frq_q <= 8'h00;
            deem_q <= 8'h00;
        end
        else if (smp && tsel_q)
        begin
            ang_q <= ang_w;
            frq_q <= ang_w - ang_q;
            deem_q <= deem_q + 8'($signed(frq_q - deem_q) >>> 2);
        end
    end
    // -------------------------------------------------------------
    // burst gating, loops, kill
    // -------------------------------------------------------------
    logic [7:0] agc_q, bamp_q, bfreq_q, prevf_q;
    logic lock_q, amp_ok_q, alt_ok_q, key_d_q;
    logic [7:0] thr, hys;
    assign thr = kill_q[7:0];
    assign hys = kill_q[15:8];
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            agc_q <= 8'h40;
            apc_trim_q <= 32'h0;
            bamp_q <= 8'h00;
            bfreq_q <= 8'h00;
            prevf_q <= 8'h00;
            lock_q <= 1'b0;
            amp_ok_q <= 1'b0;
            alt_ok_q <= 1'b0;
            key_d_q <= 1'b0;
        end
        else if (smp)
        begin
            key_d_q <= key_win;
            if (key_win)
            begin
                bamp_q <= mag_w;
                bfreq_q <= frq_q;
                if (!secam)
                begin
                    apc_trim_q <= apc_trim_q - 32'($signed(ang_w[4:0]) - 5'sh08);
                    if (mag_w < 8'h40 && agc_q < mcd_pkg::AGC_MAX)
                        agc_q <= agc_q + 8'h01;
                    else if (mag_w > 8'h40 && agc_q > mcd_pkg::AGC_MIN)
                        agc_q <= agc_q - 8'h01;
                end
            end
            if (key_d_q && !key_win)
            begin
                lock_q <= ang_w[4:2] == 3'h2;
                prevf_q <= bfreq_q;
                alt_ok_q <= bfreq_q != prevf_q;
                if (bamp_q < thr)
                    amp_ok_q <= 1'b0;
                else if ({1'b0, bamp_q} > {1'b0, thr} + {1'b0, hys})
                    amp_ok_q <= 1'b1;
            end
        end
    end
    logic kill_w;
    assign kill_w = !amp_ok_q || (secam ? !alt_ok_q : !lock_q)
        || std_w == mcd_pkg::STD_OFF;
    // -------------------------------------------------------------
    // line delay, active video only
    // -------------------------------------------------------------
    logic [7:0] ln_q [mcd_pkg::LINE_LEN];
    logic [mcd_pkg::LINE_AW-1:0] wp_q;
    logic [7:0] dl_out, cnew;
    logic [7:0] cbias;
    assign cbias = secam ? 8'(deem_q + mcd_pkg::C_MID) :
        8'(8'(tsel_q ? acc_q.q : acc_q.i) + mcd_pkg::C_MID);
    assign dl_out = ln_q[wp_q];
    assign cnew = dly_w == mcd_pkg::DLY_COMB ? vid_in : cbias;
    always_ff @(posedge clk)
    begin
        if (!nrst)
            wp_q <= '0;
        else if (line_start)
            wp_q <= '0;
        else if (smp && active_video)
        begin
            ln_q[wp_q] <= cnew;
            wp_q <= wp_q + 1'b1;
        end
    end
    // -------------------------------------------------------------
    // chroma and luma
    // -------------------------------------------------------------
    logic [7:0] c_w, y_w, notch_w, vdet_w;
    logic [8:0] avg;
    assign avg = {1'b0, cbias} + {1'b0, dl_out};
    assign c_w = kill_w ? mcd_pkg::C_MID :
        dly_w == mcd_pkg::DLY_COMP ? avg[8:1] :
        dly_w == mcd_pkg::DLY_XOVR ? dl_out : cbias;
    // notch subtracts carrier estimate from the tracking mixer
    assign notch_w = ctrl_q[mcd_pkg::CTL_COMPOSITE] ?
        8'(vid_in - 8'(mi >>> 1)) : vid_in;
    assign vdet_w = 8'((vid_in - dl_out) >>> 2);
    assign y_w = dly_w == mcd_pkg::DLY_COMB ? 8'(notch_w + vdet_w) : notch_w;
    // -------------------------------------------------------------
    // skew and scaler
    // -------------------------------------------------------------
    logic [7:0] y_d_q, c_d_q, ys, cs;
    logic [4:0] yph;
    logic [1:0] cph;
    assign yph = 5'(line_phase[7:3] + skew_q[4:0]);
    assign cph = yph[4:3];
    assign ys = 8'((13'(y_d_q) * (6'h20 - 6'(yph)) + 13'(y_w) * 6'(yph)) >> 5);
    assign cs = 8'((11'(c_d_q) * (3'h4 - 3'(cph)) + 11'(c_w) * 3'(cph)) >> 2);
    logic [15:0] sacc_q;
    logic [9:0] step_w;
    logic sc_fire;
    assign step_w = ctrl_q[mcd_pkg::CTL_NLIN] && !active_video ?
        10'(scale_q[9:0] + scale_q[25:16]) : scale_q[9:0];
    assign sc_fire = sacc_q[15:8] != 8'h00;
    logic [7:0] tcnt_q;
    mcd_pkg::mcd_pix_t tp_pix;
    assign tp_pix.valid = 1'b1;
    assign tp_pix.cb_phase = !tsel_q;
    assign tp_pix.y = tp_w == mcd_pkg::TP_YRAMP ? tcnt_q : tp_w == mcd_pkg::TP_BAR ?
        {tcnt_q[7:5], 5'h10} : mcd_pkg::Y_FLAT;
    assign tp_pix.c = tp_w == mcd_pkg::TP_CRAMP ? tcnt_q : tp_w == mcd_pkg::TP_BAR ?
        {tsel_q ^ tcnt_q[7], tcnt_q[6:5], 5'h00} : mcd_pkg::C_MID;
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            y_d_q <= 8'h00;
            c_d_q <= mcd_pkg::C_MID;
            sacc_q <= 16'h0;
            tcnt_q <= 8'h00;
            pix_out <= '0;
        end
        else if (smp)
        begin
            y_d_q <= y_w;
            c_d_q <= c_w;
            tcnt_q <= line_start ? 8'h00 : tcnt_q + 8'h01;
            if (tsel_q)
                sacc_q <= {8'h00, sacc_q[7:0]} + 16'(step_w);
            if (tp_w != mcd_pkg::TP_OFF)
                pix_out <= tp_pix;
            else
            begin
                pix_out.y <= ys;
                pix_out.c <= cs;
                pix_out.cb_phase <= !tsel_q;
                pix_out.valid <= sc_fire;
            end
        end
        else
            pix_out.valid <= 1'b0;
    end
    assign st_w = {8'h00, bfreq_q, bamp_q, agc_q[7:3], lock_q, alt_ok_q, kill_w};
endmodule

// ### mcd_pkg.sv
package mcd_pkg;
    // -------------------------------------------------------------
    // register map (byte addresses)
    // -------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_DDS = 8'h04;
    localparam logic [7:0] REG_KILL = 8'h08;
    localparam logic [7:0] REG_SCALE = 8'h0c;
    localparam logic [7:0] REG_STAT = 8'h10;
    localparam logic [7:0] REG_SKEW = 8'h14;
    // -------------------------------------------------------------
    // ctrl fields
    // -------------------------------------------------------------
    localparam int CTL_STD_LSB = 0;
    localparam int CTL_BW_LSB = 2;
    localparam int CTL_PEAK = 4;
    localparam int CTL_WIDE = 5;
    localparam int CTL_DLY_LSB = 6;
    localparam int CTL_TEST_LSB = 8;
    localparam int CTL_COMPOSITE = 11;
    localparam int CTL_NLIN = 12;
    localparam logic [31:0] CTRL_RST = 32'h0000_0840;
    localparam logic [31:0] DDS_RST = 32'h2d1c_b5a3;
    localparam logic [31:0] KILL_RST = 32'h0000_0820;
    localparam logic [31:0] SCALE_RST = 32'h0000_0100;
    localparam logic [31:0] SECAM_DDS = 32'h3633_5c4c;
    // -------------------------------------------------------------
    // modes
    // -------------------------------------------------------------
    typedef enum logic [1:0] {STD_PAL = 2'b00, STD_NTSC = 2'b01,
        STD_SECAM = 2'b10, STD_OFF = 2'b11} mcd_std_t;
    typedef enum logic [1:0] {DLY_NONE = 2'b00, DLY_COMP = 2'b01,
        DLY_COMB = 2'b10, DLY_XOVR = 2'b11} mcd_dly_t;
    typedef enum logic [2:0] {TP_OFF = 3'b000, TP_YRAMP = 3'b001, TP_CRAMP = 3'b010,
        TP_FLAT = 3'b011, TP_BAR = 3'b100} mcd_tp_t;
    localparam logic [7:0] C_MID = 8'h80;
    localparam logic [7:0] Y_FLAT = 8'h80;
    localparam int LINE_LEN = 16;
    localparam int LINE_AW = 4;
    localparam real CLK_MHZ = 250.0;
    localparam real SYS_MHZ = 20.25;
    localparam int SYS_DIV = int'(CLK_MHZ / SYS_MHZ);
    localparam logic [7:0] AGC_MAX = 8'hff;
    localparam logic [7:0] AGC_MIN = 8'h20;
    // -------------------------------------------------------------
    // pixel and iq types
    // -------------------------------------------------------------
    typedef struct packed {
        logic [7:0] y;
        logic [7:0] c;
        logic cb_phase;
        logic valid;
    } mcd_pix_t;
    typedef struct packed {
        logic signed [9:0] i;
        logic signed [9:0] q;
    } mcd_iq_t;
endpackage

// ### mcd_src.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// upstream adc/comb model: line timing, burst and subcarrier
// ------------------------------------------------------------
module mcd_src (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] amp,
    output logic [7:0] vid_in,
    output logic key_win,
    output logic active_video,
    output logic line_start,
    output logic [7:0] line_phase
);
    logic [8:0] pos_q;
    logic on;
    always_ff @(posedge clk)
    begin
        if (!nrst || pos_q == 9'h11f)
        begin
            pos_q <= 9'h000;
        end
        else
        begin
            pos_q <= pos_q + 9'h001;
        end
    end
    assign line_start = pos_q == 9'h000;
    assign key_win = pos_q >= 9'h00c && pos_q < 9'h030;
    // 192 clocks of active video give 16 samples, one delay line
    assign active_video = pos_q >= 9'h03c && pos_q < 9'h0fc;
    assign on = key_win || active_video;
    assign vid_in = !on ? 8'h80 : (pos_q[2] ? 8'h80 + amp : 8'h80 - amp);
    assign line_phase = pos_q[8:1];
endmodule

// ### mcd_color_decoder_assertions.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module mcd_chk (
    input wire logic clk,
    input wire logic nrst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire mcd_pkg::mcd_pix_t pix_out
);
    logic [4:0] gap_q;
    logic [4:0] gap_d;
    logic cb_q;
    assign gap_d = pix_out.valid ? 5'h00 : (gap_q == 5'h1f ? gap_q : gap_q + 5'h01);
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            gap_q <= 5'h1f;
            cb_q <= 1'h0;
        end
        else
        begin
            gap_q <= gap_d;
            cb_q <= pix_out.valid ? pix_out.cb_phase : cb_q;
        end
    end
    default clocking cb_clk @(posedge clk);
    endclocking
    default disable iff (!nrst);
    property p_vld_pulse;
        pix_out.valid |=> !pix_out.valid;
    endproperty
    a_vld_pulse: assert property (p_vld_pulse) else $error("valid too long");
    property p_vld_gap;
        pix_out.valid |-> gap_q >= 5'h0b;
    endproperty
    a_vld_gap: assert property (p_vld_gap) else $error("samples too close");
    property p_cb_alt;
        pix_out.valid && gap_q < 5'h1f |-> pix_out.cb_phase != cb_q;
    endproperty
    a_cb_alt: assert property (p_cb_alt) else $error("cb cr order broken");
    property p_rst_quiet;
        $rose(nrst) |-> !pix_out.valid && !s_axi_bvalid && !s_axi_rvalid;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs live after reset");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer changed");
    property p_r_next;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_r_next: assert property (p_r_next) else $error("read answer late");
    property p_b_soon;
        s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid;
    endproperty
    a_b_soon: assert property (p_b_soon) else $error("write answer late");
    property p_aw_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_aw_block: assert property (p_aw_block) else $error("write taken while pending");
endmodule
bind mcd_color_decoder mcd_chk u_chk (.clk(clk), .nrst(nrst), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pix_out(pix_out));

// ### mcd_color_decoder_tb.sv
`timescale 1ns/1ps
module mcd_color_decoder_tb;
    logic clk;
    logic nrst;
    logic [7:0] amp;
    logic [7:0] vid_in;
    logic key_win;
    logic active_video;
    logic line_start;
    logic [7:0] line_phase;
    logic [31:0] s_axi_awaddr;
    logic s_axi_awvalid;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_wvalid;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready;
    logic [31:0] s_axi_araddr;
    logic s_axi_arvalid;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready;
    mcd_pkg::mcd_pix_t pix_out;
    mcd_pkg::mcd_pix_t p1;
    mcd_pkg::mcd_pix_t p2;
    logic [31:0] rd;
    logic [1:0] rsp;
    logic [31:0] ctl [8];
    int mismatches;
    int compares;
    initial
    begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    mcd_src u_src (.clk(clk), .nrst(nrst), .amp(amp), .vid_in(vid_in), .key_win(key_win),
        .active_video(active_video), .line_start(line_start), .line_phase(line_phase));
    mcd_color_decoder uut (.clk(clk), .nrst(nrst), .vid_in(vid_in), .key_win(key_win),
        .active_video(active_video), .line_start(line_start), .line_phase(line_phase),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pix_out(pix_out));
    // ------------------------------------------------------------
    // checking and verdict
    // ------------------------------------------------------------
    task automatic conclude;
        if (mismatches == 0 && compares > 0)
        begin
            $display("TB: PASS");
        end
        else
        begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic hang;
        mismatches++;
        $display("Error %0t: wait ran out", $time);
        conclude();
    endtask
    // ------------------------------------------------------------
    // bus and stream tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        logic aw;
        logic w;
        logic b;
        aw = 1'h0;
        w = 1'h0;
        b = 1'h0;
        @(posedge clk);
        s_axi_awaddr <= {24'h000000, a};
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (n = 0; n < 50 && !(aw && w && b); n++)
        begin
            @(negedge clk);
            aw = aw || (s_axi_awvalid && s_axi_awready);
            w = w || (s_axi_wvalid && s_axi_wready);
            b = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge clk);
            s_axi_awvalid <= s_axi_awvalid && !aw;
            s_axi_wvalid <= s_axi_wvalid && !w;
        end
        s_axi_bready <= 1'h0;
        if (!b)
        begin
            hang();
        end
    endtask
    task automatic rdr(input logic [7:0] a);
        int n;
        logic t;
        t = 1'h0;
        @(posedge clk);
        s_axi_araddr <= {24'h000000, a};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (n = 0; n < 50 && !t; n++)
        begin
            @(negedge clk);
            t = s_axi_rvalid;
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge clk);
            s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
        end
        s_axi_rready <= 1'h0;
        if (!t)
        begin
            hang();
        end
    endtask
    task automatic grab(output mcd_pkg::mcd_pix_t p);
        int n;
        p = '0;
        for (n = 0; n < 400; n++)
        begin
            @(negedge clk);
            if (pix_out.valid === 1'h1)
            begin
                p = pix_out;
                return;
            end
        end
        hang();
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (100000) @(posedge clk);
        hang();
    end
    initial
    begin
        {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb, amp} = '0;
        mismatches = 0;
        compares = 0;
        ctl = '{32'h0000_0000, 32'h0000_0041, 32'h0000_0081, 32'h0000_0002, 32'h0000_0003,
            32'h0000_0018, 32'h0000_0020, 32'h0000_1801};
        repeat (16) @(posedge clk);
        nrst <= 1'h1;
        rdr(mcd_pkg::REG_STAT);
        chk(rd[0], 1'h1);
        rdr(mcd_pkg::REG_CTRL);
        chk(rd, mcd_pkg::CTRL_RST);
        rdr(mcd_pkg::REG_DDS);
        chk(rd, mcd_pkg::DDS_RST);
        rdr(mcd_pkg::REG_KILL);
        chk(rd, mcd_pkg::KILL_RST);
        rdr(mcd_pkg::REG_SCALE);
        chk(rd, mcd_pkg::SCALE_RST);
        rdr(8'h40);
        chk({rsp, rd}, {2'h2, 32'h0});
        wr(8'h44, 32'h1234_5678, 4'hf);
        chk(rsp, 2'h2);
        wr(mcd_pkg::REG_DDS, 32'h2a5b_1c3e, 4'hf);
        rdr(mcd_pkg::REG_DDS);
        chk(rd, 32'h2a5b_1c3e);
        wr(mcd_pkg::REG_KILL, 32'h0000_00ff, 4'h1);
        rdr(mcd_pkg::REG_KILL);
        chk(rd, 32'h0000_08ff);
        wr(mcd_pkg::REG_SCALE, 32'h0000_0080, 4'hf);
        rdr(mcd_pkg::REG_SCALE);
        chk(rd, 32'h0000_0080);
        wr(mcd_pkg::REG_SKEW, 32'h0000_001f, 4'hf);
        rdr(mcd_pkg::REG_SKEW);
        chk(rd[4:0], 5'h1f);
        wr(mcd_pkg::REG_SCALE, mcd_pkg::SCALE_RST, 4'hf);
        // weak burst under a full-scale threshold keeps colour killed
        amp <= 8'h10;
        for (int i = 0; i < 8; i++)
        begin
            wr(mcd_pkg::REG_CTRL, ctl[i], 4'hf);
            rdr(mcd_pkg::REG_CTRL);
            chk(rd, ctl[i]);
            grab(p1);
            grab(p2);
            chk({p1.c, p2.c}, {mcd_pkg::C_MID, mcd_pkg::C_MID});
        end
        for (int t = 1; t < 5; t++)
        begin
            wr(mcd_pkg::REG_CTRL, 32'(t) << mcd_pkg::CTL_TEST_LSB, 4'hf);
            grab(p1);
            grab(p2);
            if (t == 3)
                chk(p2.y, mcd_pkg::Y_FLAT);
            if (t == 1)
                chk(p1.y != p2.y, 1'h1);
            if (t == 2)
                chk(p1.c != p2.c, 1'h1);
        end
        @(posedge clk);
        nrst <= 1'h0;
        repeat (12) @(posedge clk);
        nrst <= 1'h1;
        rdr(mcd_pkg::REG_CTRL);
        chk(rd, mcd_pkg::CTRL_RST);
        conclude();
    end
endmodule
